/* File: rtl/cbm_pkg.sv */
// Contract
// [R1] Master issues linefill, write-back, forwards non-cacheable
// [R2] Address user sideband zero for cache bursts
// [R3] Write user sideband zero for cache bursts
// [R4] Slave flags execute-only reads when option built
// [R5] Execute-only flag uniform across a line
// [R6] Execute-only flag timed like read user
// [R7] Slave stretches with ready; master stalls
// [R8] Enable follows select; device extends with ready
// [R9] Slave error aborts the control access
// [R10] Strobe per byte, none on reads
// [R11] Control port advances only on clock enable
// [R12] Clock enable periodic, synchronous to clock
// [R13] Wake-up asserted while control activity pending
// [R14] Separate secure and non-secure interrupt outputs
// [R15] Maintenance status high during powerdown upkeep
// [R16] Capture pulse snapshots statistics counters
// [R17] Capture trigger is single synchronous pulse
// [R18] Forwarded transfers copy master identifier
// [R19] Illegal control accesses answered per config
// [R20] Downstream error reported upstream
package cbm_pkg;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned MASTER_W = 4;
  localparam int unsigned AUSER_W = 2;
  localparam int unsigned WUSER_W = 2;
  localparam int unsigned RUSER_W = 2;
  localparam int unsigned PADDR_W = 12;
  localparam int unsigned STRB_W = DATA_W / 8;
  localparam int unsigned LINE_BEATS = 4;
  localparam int unsigned BEAT_W = 2;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned BUF_DEPTH = 2;
  localparam logic [1:0] TRANS_IDLE = 2'h0;
  localparam logic [1:0] TRANS_NONSEQ = 2'h2;
  localparam logic [1:0] TRANS_SEQ = 2'h3;
  localparam logic [2:0] BURST_SINGLE = 3'h0;
  localparam logic [2:0] BURST_WRAP4 = 3'h2;
  localparam logic [2:0] SIZE_WORD = 3'h2;
  localparam logic [3:0] STRB_ALL = 4'hf;
  localparam logic [1:0] ALIGN_ZERO = 2'h0;
  localparam int unsigned PROT_PRIV = 0;
  localparam int unsigned PROT_SEC = 1;
  localparam int unsigned PROT_INSTR = 2;
  localparam logic [PADDR_W-1:0] OFF_STATUS = 12'h000;
  localparam logic [PADDR_W-1:0] OFF_HITS = 12'h004;
  localparam logic [PADDR_W-1:0] OFF_SNAP = 12'h008;
  localparam logic [PADDR_W-1:0] OFF_IRQ_CLR = 12'h00c;
  localparam logic [PADDR_W-1:0] OFF_MAINT = 12'h010;
  localparam logic [3:0] MAINT_LEN = 4'h8;
  // Kind of a downstream transfer
  typedef enum logic [1:0] {CBM_K_PASS, CBM_K_FILL, CBM_K_WBACK} cbm_kind_e;
  // One downstream request word
  typedef struct packed {
    cbm_kind_e kind;
    logic [ADDR_W-1:0] addr;
    logic write;
    logic nonsec;
    logic [6:0] prot;
    logic [MASTER_W-1:0] master;
    logic [AUSER_W-1:0] auser;
    logic [WUSER_W-1:0] wuser;
    logic [DATA_W-1:0] wdata;
  } cbm_req_s;
endpackage

/* File: rtl/cbm_link_if.sv */
`timescale 1ns/10ps
interface cbm_link_if;
  logic [1:0] htrans;
  logic [31:0] haddr;
  logic [2:0] hsize;
  logic [2:0] hburst;
  logic hwrite;
  logic hnonsec;
  logic [6:0] hprot;
  logic hmastlock;
  logic hexcl;
  logic [3:0] hmaster;
  logic [1:0] hauser;
  logic [1:0] hwuser;
  logic [31:0] hwdata;
  logic hready;
  logic hresp;
  logic hexokay;
  logic [31:0] hrdata;
  logic [1:0] hruser;
  logic hrxom;
  logic [11:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [2:0] pprot;
  logic pclken;
  logic pwakeup;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  modport dev (
    output htrans, haddr, hsize, hburst, hwrite, hnonsec, hprot, hmastlock, hexcl, hmaster,
    output hauser, hwuser, hwdata, prdata, pready, pslverr,
    input hready, hresp, hexokay, hrdata, hruser, hrxom,
    input paddr, psel, penable, pwrite, pwdata, pstrb, pprot, pclken, pwakeup
  );
  modport sys (
    input htrans, haddr, hsize, hburst, hwrite, hnonsec, hprot, hmastlock, hexcl, hmaster,
    input hauser, hwuser, hwdata, prdata, pready, pslverr,
    output hready, hresp, hexokay, hrdata, hruser, hrxom,
    output paddr, psel, penable, pwrite, pwdata, pstrb, pprot, pclken, pwakeup
  );
endinterface

/* File: rtl/cbm_dev.sv */
`timescale 1ns/10ps
module cbm_dev (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  cbm_link_if.dev link,
  input wire logic req_valid_in,
  input wire cbm_pkg::cbm_req_s req_in,
  output logic req_ready_out,
  output logic done_valid_out,
  output logic done_err_out,
  output logic done_xom_out,
  output logic [31:0] done_rdata_out,
  output logic [1:0] done_ruser_out,
  input wire logic xom_option_in,
  input wire logic snap_option_in,
  input wire logic apb_violation_resp_in,
  input wire logic pwr_maint_req_in,
  input wire logic sec_event_in,
  input wire logic nsec_event_in,
  input wire logic pmsnapshotreq_in,
  output logic sec_irq_out,
  output logic nsec_irq_out,
  output logic pwr_maintenance_out
);
  typedef enum logic [1:0] {CBM_D_IDLE, CBM_D_ADDR, CBM_D_DATA} cbm_dstate_e;
  typedef enum logic [1:0] {CBM_P_IDLE, CBM_P_SETUP, CBM_P_ACCESS} cbm_pstate_e;
  typedef struct packed {
    cbm_pkg::cbm_req_s buf0;
    cbm_pkg::cbm_req_s buf1;
    logic [1:0] cnt;
    cbm_pkg::cbm_req_s cur;
    cbm_dstate_e dst;
    logic [cbm_pkg::BEAT_W-1:0] beat;
    logic line_xom;
    logic line_err;
    logic [1:0] htrans;
    logic [31:0] haddr;
    logic [2:0] hburst;
    logic hwrite;
    logic hnonsec;
    logic [6:0] hprot;
    logic [3:0] hmaster;
    logic [1:0] hauser;
    logic [1:0] hwuser;
    logic [31:0] hwdata;
    logic dvalid;
    logic derr;
    logic dxom;
    logic [31:0] drdata;
    logic [1:0] druser;
    cbm_pstate_e pst;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [cbm_pkg::CNT_W-1:0] hits;
    logic [cbm_pkg::CNT_W-1:0] snap;
    logic sec_irq;
    logic nsec_irq;
    logic [3:0] maint_cnt;
    logic maint;
    logic rdy;
  } cbm_dev_s;

  cbm_dev_s r;
  cbm_dev_s next_r;

  // Legal control access check, shared by read and write
  function automatic logic apb_illegal(input logic wr, input logic [3:0] strb, input logic [11:0] a,
                                       input logic [2:0] prot);
    apb_illegal = (wr && strb != cbm_pkg::STRB_ALL) || (a[1:0] != cbm_pkg::ALIGN_ZERO) ||
                  prot[cbm_pkg::PROT_INSTR] || !prot[cbm_pkg::PROT_PRIV];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_r = r;
    next_r.dvalid = 1'b0;
    // Two-entry buffer fill; a stalled master never drops a word
    if (req_valid_in && r.cnt < 2'(cbm_pkg::BUF_DEPTH))
    begin
      if (r.cnt == 2'h0)
        next_r.buf0 = req_in;
      else
        next_r.buf1 = req_in;
      next_r.cnt = r.cnt + 2'h1;
    end
    // Master sequencer: NONSEQ address phase, then SEQ beats for lines, data phases held on wait states
    unique case (r.dst)
      CBM_D_IDLE:
      begin
        if (r.cnt != 2'h0)
        begin
          next_r.cur = r.buf0;
          next_r.buf0 = r.buf1;
          next_r.cnt = next_r.cnt - 2'h1;
          if (req_valid_in && r.cnt == 2'h2)
            next_r.buf1 = req_in;
          else if (req_valid_in && r.cnt == 2'h1)
            next_r.buf0 = req_in;
          next_r.htrans = cbm_pkg::TRANS_NONSEQ; // [R1]
          next_r.haddr = r.buf0.addr;
          next_r.hwrite = r.buf0.write;
          next_r.hnonsec = r.buf0.nonsec;
          next_r.hprot = r.buf0.prot;
          next_r.beat = '0;
          next_r.line_xom = 1'b0;
          next_r.line_err = 1'b0;
          if (r.buf0.kind == cbm_pkg::CBM_K_PASS)
          begin
            next_r.hburst = cbm_pkg::BURST_SINGLE;
            next_r.hmaster = r.buf0.master; // [R18]
            next_r.hauser = r.buf0.auser; // [R2]
            next_r.hwuser = r.buf0.wuser; // [R3]
          end
          else
          begin
            next_r.hburst = cbm_pkg::BURST_WRAP4;
            next_r.hmaster = '0;
            next_r.hauser = '0; // [R2]
            next_r.hwuser = '0; // [R3]
          end
          next_r.dst = CBM_D_ADDR;
        end
      end
      CBM_D_ADDR:
      begin
        if (link.hready) // [R7]
        begin
          next_r.hwdata = r.cur.wdata;
          next_r.dst = CBM_D_DATA;
          if (r.cur.kind != cbm_pkg::CBM_K_PASS && r.beat != 2'(cbm_pkg::LINE_BEATS - 1))
          begin
            next_r.htrans = cbm_pkg::TRANS_SEQ;
            next_r.haddr = r.haddr + 32'h4;
          end
          else
            next_r.htrans = cbm_pkg::TRANS_IDLE;
        end
      end
      CBM_D_DATA:
      begin
        // Data phase stalls while the slave holds ready low
        if (link.hready) // [R7]
        begin
          next_r.line_xom = r.line_xom | (xom_option_in & link.hrxom & ~r.hwrite); // [R4] [R6]
          next_r.line_err = r.line_err | link.hresp;
          if (r.htrans == cbm_pkg::TRANS_SEQ)
          begin
            // Beat address taken; issue the next one or close the line
            next_r.beat = r.beat + 2'h1;
            if (next_r.beat == 2'(cbm_pkg::LINE_BEATS - 1))
              next_r.htrans = cbm_pkg::TRANS_IDLE;
            else
              next_r.haddr = r.haddr + 32'h4;
          end
          else
          begin
            next_r.dvalid = 1'b1;
            next_r.derr = r.line_err | link.hresp; // [R20]
            next_r.dxom = r.line_xom | (xom_option_in & link.hrxom & ~r.hwrite); // [R5]
            next_r.drdata = link.hrdata;
            next_r.druser = link.hruser;
            next_r.dst = CBM_D_IDLE;
          end
          if (r.cur.kind == cbm_pkg::CBM_K_FILL && !r.hwrite)
            next_r.hits = r.hits + 16'h1;
        end
      end
      default:
        next_r.dst = CBM_D_IDLE;
    endcase
    // Control port moves only on enabled edges, so it can run at a divided rate
    if (link.pclken) // [R11]
    begin
      unique case (r.pst)
        CBM_P_IDLE:
        begin
          next_r.pready = 1'b0;
          next_r.pslverr = 1'b0;
          if (link.psel && !link.penable)
            next_r.pst = CBM_P_SETUP;
        end
        CBM_P_SETUP:
        begin
          // Answer one enabled edge into the access phase
          if (link.psel && link.penable) // [R8]
          begin
            next_r.pready = 1'b1;
            next_r.pst = CBM_P_ACCESS;
            next_r.prdata = '0;
            if (apb_illegal(link.pwrite, link.pstrb, link.paddr, link.pprot))
              next_r.pslverr = apb_violation_resp_in; // [R19] [R9]
            else if (!link.pwrite)
            begin
              unique case (link.paddr)
                cbm_pkg::OFF_STATUS: next_r.prdata = {29'h0, r.maint, r.nsec_irq, r.sec_irq};
                cbm_pkg::OFF_HITS: next_r.prdata = {16'h0, r.hits};
                cbm_pkg::OFF_SNAP: next_r.prdata = {16'h0, r.snap};
                default: next_r.pslverr = apb_violation_resp_in;
              endcase
            end
            else if (link.paddr == cbm_pkg::OFF_IRQ_CLR)
            begin
              if (link.pwdata[0] && !sec_event_in)
                next_r.sec_irq = 1'b0;
              if (link.pwdata[1] && !nsec_event_in)
                next_r.nsec_irq = 1'b0;
            end
            else if (link.paddr == cbm_pkg::OFF_MAINT)
              next_r.maint_cnt = cbm_pkg::MAINT_LEN;
          end
        end
        CBM_P_ACCESS:
        begin
          next_r.pready = 1'b0;
          next_r.pslverr = 1'b0;
          next_r.pst = CBM_P_IDLE;
        end
        default:
          next_r.pst = CBM_P_IDLE;
      endcase
    end
    // Sticky interrupts, set beats a same-cycle clear
    if (sec_event_in)
      next_r.sec_irq = 1'b1; // [R14]
    if (nsec_event_in)
      next_r.nsec_irq = 1'b1; // [R14]
    // Powerdown upkeep, status high until the sweep ends
    if (pwr_maint_req_in && r.maint_cnt == 4'h0)
      next_r.maint_cnt = cbm_pkg::MAINT_LEN;
    else if (r.maint_cnt != 4'h0)
      next_r.maint_cnt = r.maint_cnt - 4'h1;
    next_r.maint = next_r.maint_cnt != 4'h0; // [R15]
    if (snap_option_in && pmsnapshotreq_in)
      next_r.snap = r.hits; // [R16]
    next_r.rdy = next_r.cnt < 2'(cbm_pkg::BUF_DEPTH);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      r <= '0;
      r.rdy <= 1'b1;
    end
    else
      r <= next_r;
  end

  // Outputs straight from flops, except hsize, hmastlock and hexcl, which are tied off
  assign req_ready_out = r.rdy;
  assign link.htrans = r.htrans;
  assign link.haddr = r.haddr;
  assign link.hsize = cbm_pkg::SIZE_WORD;
  assign link.hburst = r.hburst;
  assign link.hwrite = r.hwrite;
  assign link.hnonsec = r.hnonsec;
  assign link.hprot = r.hprot;
  assign link.hmastlock = 1'b0;
  assign link.hexcl = 1'b0;
  assign link.hmaster = r.hmaster;
  assign link.hauser = r.hauser;
  assign link.hwuser = r.hwuser;
  assign link.hwdata = r.hwdata;
  assign link.prdata = r.prdata;
  assign link.pready = r.pready;
  assign link.pslverr = r.pslverr;
  assign done_valid_out = r.dvalid;
  assign done_err_out = r.derr;
  assign done_xom_out = r.dxom;
  assign done_rdata_out = r.drdata;
  assign done_ruser_out = r.druser;
  assign sec_irq_out = r.sec_irq;
  assign nsec_irq_out = r.nsec_irq;
  assign pwr_maintenance_out = r.maint;
endmodule

/* File: rtl/cbm_sys.sv */
`timescale 1ns/10ps
module cbm_sys (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  cbm_link_if.sys link,
  input wire logic [3:0] wait_states_in,
  input wire logic [31:0] xom_base_in,
  input wire logic [1:0] clken_div_in,
  input wire logic apb_go_in,
  input wire logic apb_write_in,
  input wire logic [11:0] apb_addr_in,
  input wire logic [31:0] apb_wdata_in,
  input wire logic [2:0] apb_prot_in,
  output logic apb_busy_out,
  output logic [31:0] apb_rdata_out,
  output logic apb_err_out,
  input wire logic snap_go_in,
  output logic pmsnapshotreq_out
);
  typedef enum logic [1:0] {CBM_Q_IDLE, CBM_Q_SETUP, CBM_Q_ACCESS} cbm_qstate_e;
  typedef struct packed {
    logic data_ph;
    logic data_wr;
    logic [31:0] data_addr;
    logic [3:0] wcnt;
    logic hready;
    logic [31:0] hrdata;
    logic hrxom;
    logic [1:0] div;
    logic pclken;
    cbm_qstate_e q;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
    logic [2:0] pprot;
    logic [31:0] rdata;
    logic err;
    logic snap_prev;
    logic snap;
  } cbm_sys_s;

  cbm_sys_s r;
  cbm_sys_s next_r;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_r = r;
    next_r.snap = snap_go_in && !r.snap_prev; // [R17]
    next_r.snap_prev = snap_go_in;
    // Periodic enable on the core clock
    next_r.div = (r.div == clken_div_in) ? 2'h0 : r.div + 2'h1;
    next_r.pclken = (r.div == clken_div_in); // [R12]
    // Slave: ready high when idle, low for the chosen wait states
    if (r.hready && link.htrans[1])
    begin
      next_r.data_ph = 1'b1;
      next_r.data_wr = link.hwrite;
      next_r.data_addr = link.haddr;
      next_r.wcnt = wait_states_in;
      next_r.hready = (wait_states_in == 4'h0);
    end
    else if (r.data_ph && !r.hready)
    begin
      next_r.wcnt = r.wcnt - 4'h1;
      next_r.hready = (r.wcnt == 4'h1); // [R7]
    end
    else if (r.hready)
      next_r.data_ph = 1'b0;
    // Answers follow the accepted address and hold through wait states
    if (r.hready && link.htrans[1])
    begin
      next_r.hrdata = link.haddr;
      // Whole-line region compare keeps the flag uniform per line
      next_r.hrxom = !link.hwrite && (link.haddr[31:4] >= xom_base_in[31:4]); // [R4] [R5] [R6]
    end
    // Requester: setup then access, strobes full only on writes
    if (r.pclken)
    begin
      unique case (r.q)
        CBM_Q_IDLE:
        begin
          if (apb_go_in)
          begin
            next_r.psel = 1'b1;
            next_r.pwrite = apb_write_in;
            next_r.paddr = apb_addr_in;
            next_r.pwdata = apb_wdata_in;
            next_r.pprot = apb_prot_in;
            next_r.pstrb = apb_write_in ? 4'hf : 4'h0; // [R10]
            next_r.q = CBM_Q_SETUP;
          end
        end
        CBM_Q_SETUP:
        begin
          next_r.penable = 1'b1; // [R8]
          next_r.q = CBM_Q_ACCESS;
        end
        CBM_Q_ACCESS:
        begin
          if (link.pready)
          begin
            next_r.psel = 1'b0;
            next_r.penable = 1'b0;
            next_r.pstrb = 4'h0;
            next_r.rdata = link.prdata;
            next_r.err = link.pslverr;
            next_r.q = CBM_Q_IDLE;
          end
        end
        default:
          next_r.q = CBM_Q_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      r <= '0;
      r.hready <= 1'b1;
    end
    else
      r <= next_r;
  end

  assign link.hready = r.hready;
  assign link.hresp = 1'b0;
  assign link.hexokay = 1'b0;
  assign link.hrdata = r.hrdata;
  assign link.hruser = 2'h0;
  assign link.hrxom = r.hrxom;
  assign link.paddr = r.paddr;
  assign link.psel = r.psel;
  assign link.penable = r.penable;
  assign link.pwrite = r.pwrite;
  assign link.pwdata = r.pwdata;
  assign link.pstrb = r.pstrb;
  assign link.pprot = r.pprot;
  assign link.pclken = r.pclken;
  assign link.pwakeup = r.psel; // [R13]
  assign apb_busy_out = r.psel;
  assign apb_rdata_out = r.rdata;
  assign apb_err_out = r.err;
  assign pmsnapshotreq_out = r.snap;
endmodule

/* File: tb/cbm_link_chk.sv */
`timescale 1ns/10ps
module cbm_link_chk (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [1:0] htrans,
  input wire logic [31:0] haddr,
  input wire logic [2:0] hburst,
  input wire logic hwrite,
  input wire logic [3:0] hmaster,
  input wire logic [1:0] hauser,
  input wire logic [1:0] hwuser,
  input wire logic hready,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pclken
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////////////////////////
  // Master side: lines are WRAP4, cache bursts carry no sidebands
  property p_hold; htrans != 2'h0 && !hready |=> $stable(haddr) && $stable(htrans); endproperty
  a_hold: assert property (p_hold) else $error("address moved in wait");
  property p_auser; htrans == 2'h2 && hburst == 3'h2 |-> hauser == 2'h0; endproperty
  a_auser: assert property (p_auser) else $error("line address sideband set");
  property p_wuser; htrans == 2'h3 && hwrite |-> hwuser == 2'h0; endproperty
  a_wuser: assert property (p_wuser) else $error("line write sideband set");
  property p_lmaster; htrans != 2'h0 && hburst == 3'h2 |-> hmaster == 4'h0; endproperty
  a_lmaster: assert property (p_lmaster) else $error("line master id set");
  property p_seq; htrans == 2'h3 |-> hburst == 3'h2; endproperty
  a_seq: assert property (p_seq) else $error("sequential beat outside line");
  property p_step; htrans == 2'h3 && $past(hready) && $past(htrans) != 2'h0 |-> haddr == $past(haddr) + 32'h4; endproperty
  a_step: assert property (p_step) else $error("beat address step wrong");
  ////////////////////////////////////////////////////////////
  // Control port: access phase framing, gated by the enable
  property p_en; $rose(penable) |-> $past(psel) && psel; endproperty
  a_en: assert property (p_en) else $error("enable without setup");
  property p_rdy; pready |-> psel && penable; endproperty
  a_rdy: assert property (p_rdy) else $error("ready outside access");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_gate; !pclken |=> $stable(penable) && $stable(pready); endproperty
  a_gate: assert property (p_gate) else $error("moved without clock enable");
  property p_end; pready && pclken |=> !penable; endproperty
  a_end: assert property (p_end) else $error("access not closed");
  // Main scenarios reached
  c_line: cover property (htrans == 2'h2 && hburst == 3'h2 && hready);
  c_wait: cover property (htrans != 2'h0 && !hready);
  c_slverr: cover property (pslverr && pready);
endmodule

/* File: tb/tb_cache_bus_master_and_ctrl_ports.sv */
`timescale 1ns/10ps
module tb_cache_bus_master_and_ctrl_ports;
  typedef struct packed {logic err; logic chk; logic [31:0] data;} cbm_apb_exp_s;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic req_valid = 1'b0;
  cbm_pkg::cbm_req_s req = '0;
  cbm_pkg::cbm_req_s we;
  logic req_ready, done_valid, done_err, done_xom, pm, sec_irq, nsec_irq, maint, busy, apb_err;
  logic [31:0] done_rdata, apb_rdata;
  logic [1:0] done_ruser;
  logic xom_opt = 0, viol = 0, maint_req = 0, sec_ev = 0, nsec_ev = 0, go = 0, wr = 0, snap_go = 0;
  logic [3:0] ws = 0;
  logic [1:0] div = 0;
  logic [11:0] pa = 0;
  logic [31:0] pwd = 0;
  logic [2:0] pp = 3'h1;
  logic pb = 0, saw_full = 0, snap_opt = 1, lin;
  int error_cnt = 0, samples_checked = 0, cycles = 0, mcnt = 0, hits = 0;
  integer seed = 32'hc716c3d2;
  cbm_pkg::cbm_req_s wq[$];
  logic xq[$];
  logic [31:0] dq[$];
  cbm_apb_exp_s aq[$], ae;

  cbm_link_if link();
  cbm_dev i_cbm_dev (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .link(link), .req_valid_in(req_valid),
    .req_in(req), .req_ready_out(req_ready), .done_valid_out(done_valid), .done_err_out(done_err),
    .done_xom_out(done_xom), .done_rdata_out(done_rdata), .done_ruser_out(done_ruser),
    .xom_option_in(xom_opt), .snap_option_in(snap_opt), .apb_violation_resp_in(viol), .pwr_maint_req_in(maint_req),
    .sec_event_in(sec_ev), .nsec_event_in(nsec_ev), .pmsnapshotreq_in(pm), .sec_irq_out(sec_irq),
    .nsec_irq_out(nsec_irq), .pwr_maintenance_out(maint));
  cbm_sys i_cbm_sys (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .link(link), .wait_states_in(ws),
    .xom_base_in(32'h8000_0000), .clken_div_in(div), .apb_go_in(go), .apb_write_in(wr), .apb_addr_in(pa),
    .apb_wdata_in(pwd), .apb_prot_in(pp), .apb_busy_out(busy), .apb_rdata_out(apb_rdata),
    .apb_err_out(apb_err), .snap_go_in(snap_go), .pmsnapshotreq_out(pm));
  cbm_link_chk i_cbm_link_chk (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .htrans(link.htrans),
    .haddr(link.haddr), .hburst(link.hburst), .hwrite(link.hwrite), .hmaster(link.hmaster),
    .hauser(link.hauser), .hwuser(link.hwuser), .hready(link.hready), .psel(link.psel),
    .penable(link.penable), .pready(link.pready), .pslverr(link.pslverr), .pclken(link.pclken));

  ////////////////////////////////////////////////////////////
  // 50 ns period
  always #25 sys_clk_in = ~sys_clk_in;

  // Hang guard, well above the expected run
  always @(posedge sys_clk_in)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      error_cnt++;
      end_sim();
    end
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task end_sim;
    $display("Checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Push one request; valid stays up so pushes run back to back
  task push(input logic [1:0] k, input logic w);
    cbm_pkg::cbm_req_s r;
    logic [95:0] rv;
    rv = {$random(seed), $random(seed), $random(seed)};
    r = rv[82:0];
    r.kind = cbm_pkg::cbm_kind_e'(k);
    r.write = w;
    r.addr[3:0] = 4'h0;
    @(negedge sys_clk_in);
    ws = 4'($random(seed)) & 4'h3;
    req = r;
    req_valid = 1'b1;
    for (int i = 0; i < 400 && req_ready !== 1'b1; i++)
    begin
      saw_full = 1'b1;
      @(negedge sys_clk_in);
    end
    @(posedge sys_clk_in);
    wq.push_back(r);
    xq.push_back(xom_opt && !w && r.addr >= 32'h8000_0000);
    dq.push_back(r.kind == cbm_pkg::CBM_K_PASS ? r.addr : r.addr + 32'hc);
    if (r.kind == cbm_pkg::CBM_K_FILL)
      hits += 4;
  endtask

  // One control access; level request dropped once the port is busy
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [2:0] p, input logic e,
    input logic c, input logic [31:0] x);
    @(negedge sys_clk_in);
    aq.push_back('{e, c, x});
    go = 1'b1;
    wr = w;
    pa = a;
    pwd = d;
    pp = p;
    for (int i = 0; i < 100 && busy !== 1'b1; i++)
      @(negedge sys_clk_in);
    go = 1'b0;
    for (int i = 0; i < 100 && busy !== 1'b0; i++)
      @(negedge sys_clk_in);
  endtask

  ////////////////////////////////////////////////////////////
  // Wire and completion monitor, sampled before the edge updates land
  always @(posedge sys_clk_in)
  begin
    if (maint === 1'b1)
      mcnt++;
    if (rst_n_in && link.htrans === cbm_pkg::TRANS_NONSEQ && link.hready === 1'b1 && wq.size() > 0)
    begin
      we = wq.pop_front();
      lin = we.kind != cbm_pkg::CBM_K_PASS;
      check(link.haddr, we.addr);
      check(32'(link.hburst), lin ? 32'(cbm_pkg::BURST_WRAP4) : 32'(cbm_pkg::BURST_SINGLE));
      check(32'(link.hwrite), 32'(we.write));
      check(32'(link.hmaster), lin ? 32'h0 : 32'(we.master));
      check(32'(link.hauser), lin ? 32'h0 : 32'(we.auser));
      check(32'(link.hwuser), lin ? 32'h0 : 32'(we.wuser));
    end
    if (done_valid === 1'b1)
    begin
      check(32'(done_err), 32'h0);
      check(32'(done_xom), 32'(xq.pop_front()));
      check(done_rdata, dq.pop_front());
    end
  end

  // Control port results, taken as busy falls
  always @(negedge sys_clk_in)
  begin
    if (pb === 1'b1 && busy === 1'b0 && aq.size() > 0)
    begin
      ae = aq.pop_front();
      check(32'(apb_err), 32'(ae.err));
      if (ae.chk)
        check(apb_rdata, ae.data);
    end
    pb = busy;
  end

  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    check(32'({sec_irq, nsec_irq, maint, req_ready}), 32'h1);
    $display("Test reset done");
    // Mixed traffic with random waits, xom option off then on
    for (int xo = 0; xo < 2; xo++)
    begin
      xom_opt = 1'(xo);
      for (int n = 0; n < 15; n++)
        push(2'(n % 3), n % 3 == 2 || (n % 3 == 0 && n[2]));
      @(negedge sys_clk_in) req_valid = 1'b0;
      for (int i = 0; i < 3000 && xq.size() > 0; i++)
        @(negedge sys_clk_in);
      check(32'(xq.size()), 32'h0);
    end
    check(32'(saw_full), 32'h1);
    $display("Test traffic done");
    // Separate lines per security event, cleared one by one
    @(negedge sys_clk_in) sec_ev = 1'b1;
    @(negedge sys_clk_in) sec_ev = 1'b0;
    repeat (2) @(negedge sys_clk_in);
    check(32'({sec_irq, nsec_irq}), 32'h2);
    @(negedge sys_clk_in) nsec_ev = 1'b1;
    @(negedge sys_clk_in) nsec_ev = 1'b0;
    apb(1'b0, cbm_pkg::OFF_STATUS, 32'h0, 3'h1, 1'b0, 1'b1, 32'h3);
    apb(1'b1, cbm_pkg::OFF_IRQ_CLR, 32'h1, 3'h1, 1'b0, 1'b0, 32'h0);
    check(32'({sec_irq, nsec_irq}), 32'h1);
    apb(1'b1, cbm_pkg::OFF_IRQ_CLR, 32'h2, 3'h1, 1'b0, 1'b0, 32'h0);
    check(32'({sec_irq, nsec_irq}), 32'h0);
    $display("Test interrupts done");
    // Maintenance from software, then from the request pin
    mcnt = 0;
    apb(1'b1, cbm_pkg::OFF_MAINT, 32'h1, 3'h1, 1'b0, 1'b0, 32'h0);
    repeat (20) @(negedge sys_clk_in);
    check(32'(mcnt), 32'(cbm_pkg::MAINT_LEN));
    @(negedge sys_clk_in) maint_req = 1'b1;
    @(negedge sys_clk_in) maint_req = 1'b0;
    repeat (20) @(negedge sys_clk_in);
    check(32'(mcnt), 32'(2 * cbm_pkg::MAINT_LEN));
    $display("Test maintenance done");
    // Counter capture through the trigger pulse
    apb(1'b0, cbm_pkg::OFF_HITS, 32'h0, 3'h1, 1'b0, 1'b1, 32'(hits));
    for (int so = 0; so < 2; so++)
    begin
      snap_opt = 1'(so);
      @(negedge sys_clk_in) snap_go = 1'b1;
      @(negedge sys_clk_in) snap_go = 1'b0;
      repeat (4) @(negedge sys_clk_in);
      apb(1'b0, cbm_pkg::OFF_SNAP, 32'h0, 3'h1, 1'b0, 1'b1, so ? 32'(hits) : 32'h0);
    end
    $display("Test snapshot done");
    // Illegal accesses under both responses and every divider
    for (int v = 0; v < 8; v++)
    begin
      viol = v[0];
      div = 2'(v >> 1);
      apb(1'b0, 12'h002, 32'h0, 3'h1, viol, 1'b0, 32'h0);
      apb(1'b1, cbm_pkg::OFF_MAINT, 32'h1, 3'h5, viol, 1'b0, 32'h0);
      apb(1'b0, cbm_pkg::OFF_STATUS, 32'h0, 3'h0, viol, 1'b0, 32'h0);
      apb(1'b0, 12'h100, 32'h0, 3'h1, viol, 1'b0, 32'h0);
      apb(1'b0, cbm_pkg::OFF_STATUS, 32'h0, 3'h1, 1'b0, 1'b1, 32'h0);
    end
    check(32'(mcnt), 32'(2 * cbm_pkg::MAINT_LEN));
    $display("Test control port done");
    end_sim();
  end
endmodule
